// *** hdl/linear_array_scan_sequencer.sv ***
// Scan and readout sequencer of a linear photodiode array with Avalon-MM registers
// Operation
// - First pixel presented at 23rd falling edge
// - Next pixels follow every four scan clock cycles
// - Scan done low during last pixel
// - Integrate from 2nd fall to 7th fall
// - Line edges frame integration and start readout
// - Sample valid pulse marks sampling window
// - Pitch select sets pixel count, half coarse
// - Gain select chooses feedback capacitance setting
// - Master starts from line pulse, ignores chain
// - Slave starts from chain start input
// - Pixel rate is quarter scan clock
// - Scan clock between 40 and 4000 kHz
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module linear_array_scan_sequencer
    import scan_pkg::*;
#(
    parameter int FINE_PIXELS = scan_pkg::FINE_PIXELS_DEFAULT
) (
    input wire logic clk, // System clock, 25 MHz
    input wire logic rst, // Synchronous reset, high
    input wire logic scan_clk, // Scan clock pin
    input wire logic line_n, // Line pulse pin, active low
    input wire logic chain_start_in_n, // Chain start pin, active low
    input wire logic chain_role_select, // High for master
    input wire logic pitch_select, // High for fine pitch
    input wire logic gain_select, // High for high sensitivity
    output logic sample_valid, // Sampling window pulse
    output logic scan_done_out_n, // Last pixel marker, active low
    output logic video_valid, // A pixel is on the video output
    output logic [15:0] pixel_index, // Pixel now on the video output
    output logic integrating, // Charge integration active
    output logic feedback_high_sens, // Feedback select for the amplifiers
    input wire logic [3:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte enables
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest // Stall
);
    import scan_pkg::*;

    pin_sync_if #(.WIDTH(PIN_COUNT)) sync ();

    pin_sync #(.WIDTH(PIN_COUNT), .CLK_BIT(PIN_SCLK)) u_sync (
        .clk(clk),
        .rst(rst),
        .pins({gain_select, pitch_select, chain_role_select, chain_start_in_n, line_n, scan_clk}),
        .sync(sync.drive)
    );

    logic fall;
    logic line_now;
    logic line_lvl;
    logic chain_lvl;
    logic role_master;
    logic rise_ev;
    logic fall_ev;
    logic [15:0] edge_cnt;
    logic [15:0] pixel_count;
    logic enable;
    logic err_rise;
    logic err_low;
    logic err_clk;
    logic [31:0] line_total;
    readout_state_type state;
    readout_state_type next_state;
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic [15:0] next_index;
    logic [1:0] slave_cnt;
    logic [1:0] next_slave_cnt;
    logic [10:0] period_cnt;
    logic period_seen;
    logic bus_ack;
    logic reading;

    assign fall = sync.sclk_fall;
    assign line_now = sync.level[PIN_LINE];
    assign role_master = sync.level[PIN_ROLE];
    assign rise_ev = fall & line_now & ~line_lvl;
    assign fall_ev = fall & ~line_now & line_lvl;
    assign reading = (state == RD_PIXELS);

    // Line level and chain level as seen at scan clock falling edges
    always_ff @(posedge clk) begin
        if (rst) begin
            line_lvl <= 1'b1;
            chain_lvl <= 1'b1;
        end else if (fall) begin
            line_lvl <= line_now;
            chain_lvl <= sync.level[PIN_CHAIN];
        end
    end

    // Falling edges since the last line edge, saturating
    always_ff @(posedge clk) begin
        if (rst) begin
            edge_cnt <= 16'h0000;
        end else if (rise_ev || fall_ev) begin
            edge_cnt <= 16'h0001;
        end else if (fall && edge_cnt != 16'hFFFF) begin
            edge_cnt <= edge_cnt + 16'h0001;
        end
    end

    // Integration window framed by the line edges
    always_ff @(posedge clk) begin
        if (rst) begin
            integrating <= 1'b0;
        end else if (fall && !rise_ev && !fall_ev) begin
            if (line_lvl && enable && edge_cnt == INTEG_START_FALLS - 16'h0001) begin
                integrating <= 1'b1;
            end else if (!line_lvl && edge_cnt == INTEG_END_FALLS - 16'h0001) begin
                integrating <= 1'b0;
            end
        end
    end

    // Static selections
    always_ff @(posedge clk) begin
        if (rst) begin
            pixel_count <= 16'(FINE_PIXELS / 2);
            feedback_high_sens <= 1'b0;
        end else begin
            pixel_count <= sync.level[PIN_PITCH] ? 16'(FINE_PIXELS) : 16'(FINE_PIXELS / 2);
            feedback_high_sens <= sync.level[PIN_GAIN];
        end
    end

    // Readout sequencer next state
    always_comb begin
        next_state = state;
        next_phase = phase;
        next_index = pixel_index;
        next_slave_cnt = slave_cnt;
        if (fall) begin
            if (rise_ev) begin
                next_state = enable ? RD_ARMED : RD_IDLE;
            end else begin
                unique case (state)
                    RD_IDLE: begin
                        next_state = RD_IDLE;
                    end
                    RD_ARMED: begin
                        if (role_master) begin
                            if (line_lvl && edge_cnt == FIRST_PIXEL_FALLS - 16'h0001) begin
                                next_state = RD_PIXELS;
                                next_phase = 2'h0;
                                next_index = 16'h0000;
                            end
                        end else if (chain_lvl && !sync.level[PIN_CHAIN]) begin
                            next_state = RD_DELAY;
                            next_slave_cnt = SLAVE_DELAY_FALLS - 2'h1;
                        end
                    end
                    RD_DELAY: begin
                        if (slave_cnt == 2'h0) begin
                            next_state = RD_PIXELS;
                            next_phase = 2'h0;
                            next_index = 16'h0000;
                        end else begin
                            next_slave_cnt = slave_cnt - 2'h1;
                        end
                    end
                    RD_PIXELS: begin
                        if (phase != PIXEL_LAST_PHASE) begin
                            next_phase = phase + 2'h1;
                        end else if (pixel_index == pixel_count - 16'h0001) begin
                            next_state = RD_IDLE;
                        end else begin
                            next_phase = 2'h0;
                            next_index = pixel_index + 16'h0001;
                        end
                    end
                endcase
            end
        end
    end

    // Readout sequencer registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= RD_IDLE;
            phase <= 2'h0;
            pixel_index <= 16'h0000;
            slave_cnt <= 2'h0;
            video_valid <= 1'b0;
            scan_done_out_n <= 1'b1;
        end else begin
            state <= next_state;
            phase <= next_phase;
            pixel_index <= next_index;
            slave_cnt <= next_slave_cnt;
            video_valid <= (next_state == RD_PIXELS);
            scan_done_out_n <= !(next_state == RD_PIXELS
                                 && next_index == pixel_count - 16'h0001);
        end
    end

    // Sampling window: one scan clock period, rise to rise, from the rise after each pixel update
    always_ff @(posedge clk) begin
        if (rst) begin
            sample_valid <= 1'b0;
        end else if (!reading) begin
            sample_valid <= 1'b0;
        end else if (sync.sclk_rise) begin
            sample_valid <= (phase == 2'h0);
        end
    end

    // Scan clock period check
    always_ff @(posedge clk) begin
        if (rst) begin
            period_cnt <= 11'h000;
            period_seen <= 1'b0;
        end else if (fall) begin
            period_cnt <= 11'h001;
            period_seen <= 1'b1;
        end else if (period_cnt != 11'h7FF) begin
            period_cnt <= period_cnt + 11'h001;
        end
    end

    // Line counter
    always_ff @(posedge clk) begin
        if (rst) begin
            line_total <= 32'h0000_0000;
        end else if (rise_ev && enable) begin
            line_total <= line_total + 32'h0000_0001;
        end
    end

    // Control register and sticky errors; a new error wins over its clear
    always_ff @(posedge clk) begin
        if (rst) begin
            enable <= CONTROL_ENABLE_RESET;
            err_rise <= 1'b0;
            err_low <= 1'b0;
            err_clk <= 1'b0;
        end else begin
            if (bus_ack && avs_write && avs_address == OFS_CONTROL && avs_byteenable[0]) begin
                enable <= avs_writedata[CTL_ENABLE];
            end
            if (rise_ev && (reading || state == RD_DELAY)) begin
                err_rise <= 1'b1;
            end else if (bus_ack && avs_write && avs_address == OFS_STATUS && avs_byteenable[1]
                         && avs_writedata[ST_ERR_RISE]) begin
                err_rise <= 1'b0;
            end
            if (rise_ev && (edge_cnt < LOW_MIN_FALLS || edge_cnt[1:0] != 2'h0)) begin
                err_low <= 1'b1;
            end else if (bus_ack && avs_write && avs_address == OFS_STATUS && avs_byteenable[1]
                         && avs_writedata[ST_ERR_LOW]) begin
                err_low <= 1'b0;
            end
            if ((fall && period_seen && period_cnt + 11'h001 < 11'(SCLK_MIN_CYC))
                || period_cnt > 11'(SCLK_MAX_CYC + 1)) begin
                err_clk <= 1'b1;
            end else if (bus_ack && avs_write && avs_address == OFS_STATUS && avs_byteenable[1]
                         && avs_writedata[ST_ERR_CLK]) begin
                err_clk <= 1'b0;
            end
        end
    end

    // Bus slave: one wait state, then the answer
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            bus_ack <= (avs_read || avs_write) && !bus_ack;
            if (avs_read && !bus_ack) begin
                unique case (avs_address)
                    OFS_CONTROL: avs_readdata <= {31'h0000_0000, enable};
                    OFS_STATUS: avs_readdata <= {21'h00_0000, err_clk, err_low, err_rise,
                                                 3'h0, role_master, feedback_high_sens,
                                                 sync.level[PIN_PITCH], reading, integrating};
                    OFS_PIXELS: avs_readdata <= {pixel_index, pixel_count};
                    OFS_LINES: avs_readdata <= line_total;
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

    // Checks
    property p_first_pixel;
        @(posedge clk) disable iff (rst)
        (state == RD_ARMED && role_master && fall && !rise_ev && line_lvl
         && edge_cnt == 16'h0016) |=> (reading && pixel_index == 16'h0000 && video_valid);
    endproperty
    a_first_pixel: assert property (p_first_pixel) else $error("first pixel not started");

    property p_master_start;
        @(posedge clk) disable iff (rst)
        $rose(reading) && role_master |-> $past(edge_cnt) == 16'h0016;
    endproperty
    a_master_start: assert property (p_master_start) else $error("master start misplaced");

    property p_slave_start;
        @(posedge clk) disable iff (rst)
        $rose(reading) && !role_master |-> $past(state) == RD_DELAY && $past(slave_cnt) == 2'h0;
    endproperty
    a_slave_start: assert property (p_slave_start) else $error("slave start misplaced");

    property p_pixel_step;
        @(posedge clk) disable iff (rst)
        reading && $past(reading) && pixel_index != $past(pixel_index)
            |-> $past(phase) == 2'h3 && $past(fall) && pixel_index == $past(pixel_index) + 16'h0001;
    endproperty
    a_pixel_step: assert property (p_pixel_step) else $error("pixel step not every four");

    sequence s_phase_wrap;
        reading && fall && phase == 2'h3;
    endsequence
    property p_quarter_rate;
        @(posedge clk) disable iff (rst)
        reading && fall && phase != 2'h3 |=> $stable(pixel_index) && phase == $past(phase) + 2'h1;
    endproperty
    a_quarter_rate: assert property (p_quarter_rate) else $error("pixel rate wrong");

    property p_done_last;
        @(posedge clk) disable iff (rst)
        !scan_done_out_n |-> reading && pixel_index == pixel_count - 16'h0001;
    endproperty
    a_done_last: assert property (p_done_last) else $error("scan done outside last pixel");

    property p_integ_start;
        @(posedge clk) disable iff (rst)
        $rose(integrating) |-> $past(line_lvl) && $past(edge_cnt) == 16'h0001 && $past(fall);
    endproperty
    a_integ_start: assert property (p_integ_start) else $error("integration start wrong");

    property p_integ_end;
        @(posedge clk) disable iff (rst)
        $fell(integrating) |-> !$past(line_lvl) && $past(edge_cnt) == 16'h0006;
    endproperty
    a_integ_end: assert property (p_integ_end) else $error("integration end wrong");

    property p_sample_window;
        @(posedge clk) disable iff (rst)
        $rose(sample_valid) |-> reading && phase == 2'h0 && $past(sync.sclk_rise);
    endproperty
    a_sample_window: assert property (p_sample_window) else $error("sample pulse misplaced");

    property p_wrap_valid;
        @(posedge clk) disable iff (rst)
        s_phase_wrap ##0 (pixel_index == pixel_count - 16'h0001 && !rise_ev)
            |=> !video_valid && scan_done_out_n ##1 !sample_valid;
    endproperty
    a_wrap_valid: assert property (p_wrap_valid) else $error("sample pulse after end");

    property p_pitch_count;
        @(posedge clk) disable iff (rst)
        $past(sync.level[PIN_PITCH]) == 1'b0 |-> pixel_count == 16'(FINE_PIXELS / 2);
    endproperty
    a_pitch_count: assert property (p_pitch_count) else $error("coarse pixel count wrong");

    property p_clk_slow;
        @(posedge clk) disable iff (rst)
        period_cnt == 11'(SCLK_MAX_CYC + 2) |=> err_clk;
    endproperty
    a_clk_slow: assert property (p_clk_slow) else $error("slow scan clock not flagged");
endmodule : linear_array_scan_sequencer

// *** hdl/pin_sync.sv ***
// Two-stage synchronisers for all pins and scan clock edge detection
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 6,
    parameter int CLK_BIT = 0
) (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic [WIDTH-1:0] pins, // Raw pin levels
    pin_sync_if.drive sync // Synchronised outputs
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic clk_prev;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                end else begin
                    stage1[i] <= pins[i];
                    stage2[i] <= stage1[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= stage2[CLK_BIT];
        end
    end

    assign sync.level = stage2;
    assign sync.sclk_fall = clk_prev & ~stage2[CLK_BIT];
    assign sync.sclk_rise = ~clk_prev & stage2[CLK_BIT];
endmodule : pin_sync

// *** pkg/pin_sync_if.sv ***
// Synchronised pin levels and scan clock edge strobes
`timescale 1ns/1ps
interface pin_sync_if #(parameter int WIDTH = 6);
    logic [WIDTH-1:0] level;
    logic sclk_fall;
    logic sclk_rise;
    modport drive (output level, output sclk_fall, output sclk_rise);
    modport use_side (input level, input sclk_fall, input sclk_rise);
endinterface : pin_sync_if

// *** pkg/scan_pkg.sv ***
// Constants and types shared by the linear array scan sequencer
package scan_pkg;
    // System clock
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;
    // Scan clock limits: 4000 kHz fastest, 40 kHz slowest
    localparam int SCLK_MIN_PERIOD_NS = 250;
    localparam int SCLK_MAX_PERIOD_NS = 25_000;
    localparam int SCLK_MIN_CYC = (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_MAX_CYC = SCLK_MAX_PERIOD_NS / CLK_PERIOD_NS;
    // Sequencing in scan clock falling edges
    localparam logic [15:0] INTEG_START_FALLS = 16'h0002;
    localparam logic [15:0] INTEG_END_FALLS = 16'h0007;
    localparam logic [15:0] FIRST_PIXEL_FALLS = 16'h0017;
    localparam logic [1:0] PIXEL_LAST_PHASE = 2'h3;
    localparam logic [15:0] LOW_MIN_FALLS = 16'h000C;
    localparam logic [1:0] SLAVE_DELAY_FALLS = 2'h3;
    // Default pixel count at fine pitch
    localparam int FINE_PIXELS_DEFAULT = 3072;
    // Pin vector positions
    localparam int PIN_SCLK = 0;
    localparam int PIN_LINE = 1;
    localparam int PIN_CHAIN = 2;
    localparam int PIN_ROLE = 3;
    localparam int PIN_PITCH = 4;
    localparam int PIN_GAIN = 5;
    localparam int PIN_COUNT = 6;
    // Register byte offsets
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_PIXELS = 4'h8;
    localparam logic [3:0] OFS_LINES = 4'hC;
    // Field positions
    localparam int CTL_ENABLE = 0;
    localparam int ST_INTEG = 0;
    localparam int ST_READ = 1;
    localparam int ST_FINE = 2;
    localparam int ST_GAIN = 3;
    localparam int ST_MASTER = 4;
    localparam int ST_ERR_RISE = 8;
    localparam int ST_ERR_LOW = 9;
    localparam int ST_ERR_CLK = 10;
    localparam logic CONTROL_ENABLE_RESET = 1'b1;
    // Readout sequencer states
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_ARMED = 2'b01,
        RD_DELAY = 2'b10,
        RD_PIXELS = 2'b11
    } readout_state_type;
endpackage : scan_pkg

// *** testbench/scan_ctrl_model.sv ***
// Scan controller model driving scan clock, line pulse and chain start
`timescale 1ns/1ps
module scan_ctrl_model #(
    parameter int HALF = 6
) (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic [7:0] low_len, // Line low length in falls
    input wire logic [7:0] high_len, // Line high length in falls
    input wire logic stall, // Freeze the scan clock
    output logic scan_clk, // Scan clock pin
    output logic line_n, // Line pulse pin
    output logic chain_start_in_n // Chain start pin
);
    int ph;
    int k;
    logic [7:0] lim;
    // Free running scan clock inside the legal band
    always_ff @(posedge clk) begin
        if (rst) begin
            ph <= 0;
            scan_clk <= 1'b1;
        end else if (!stall) begin
            ph <= (ph + 1) % (2 * HALF);
            scan_clk <= ((ph + 1) % (2 * HALF)) < HALF;
        end
    end
    // Pins move mid-high, clear of the falls that sample them
    always_ff @(posedge clk) begin
        if (rst) begin
            line_n <= 1'b0;
            // First low phase spans low_len falls like every later one
            k <= -1;
            lim <= low_len;
            chain_start_in_n <= 1'b1;
        end else if (ph == HALF / 2 && !stall) begin
            k <= k + 1;
            if (k + 1 == int'(lim)) begin
                line_n <= ~line_n;
                k <= 0;
                lim <= line_n ? low_len : high_len;
            end
            chain_start_in_n <= !(line_n && k >= 28 && k < 32);
        end
    end
endmodule : scan_ctrl_model

// *** testbench/testbench.sv ***
// Testbench of the linear array scan sequencer
`timescale 1ns/1ps
module testbench;
    import scan_pkg::*;
    localparam int NF = 8;
    localparam int HP = 6;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic role = 1'b1;
    logic pitch = 1'b1;
    logic gain = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sample_valid, scan_done_out_n, video_valid, integrating, feedback_high_sens;
    logic [15:0] pixel_index;
    logic [15:0] pidx = 16'h0;
    logic scan_clk, line_n, chain_start_in_n;
    logic [7:0] low_len = 8'd12;
    logic [7:0] high_len = 8'd80;
    logic stall = 1'b0;
    logic ps = 1'b1, pvv = 1'b0, pint = 1'b0, psv = 1'b0, peos = 1'b1;
    logic [31:0] r, l0;
    int fc = 0, fl = 0, first_fc = 0, integ_fc = 0, integ_fl = 0, sv_cnt = 0;
    int gap = 0, gap_bad = 0, eos_len = 0, eos_idx = 0, vv_rises = 0, v0;
    int failures = 0;
    int checked = 0;
    always #20 clk = ~clk;
    linear_array_scan_sequencer #(.FINE_PIXELS(NF)) DUT (.clk(clk), .rst(rst),
        .scan_clk(scan_clk), .line_n(line_n), .chain_start_in_n(chain_start_in_n),
        .chain_role_select(role), .pitch_select(pitch), .gain_select(gain),
        .sample_valid(sample_valid), .scan_done_out_n(scan_done_out_n),
        .video_valid(video_valid), .pixel_index(pixel_index), .integrating(integrating),
        .feedback_high_sens(feedback_high_sens), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    scan_ctrl_model #(.HALF(HP)) partner (.clk(clk), .rst(rst), .low_len(low_len),
        .high_len(high_len), .stall(stall), .scan_clk(scan_clk), .line_n(line_n),
        .chain_start_in_n(chain_start_in_n));
    // Falls are counted from the pins, outputs timed against those counts
    always @(posedge clk) begin
        if (ps && !scan_clk) begin
            fc = line_n ? fc + 1 : 0;
            fl = line_n ? 0 : fl + 1;
            if (line_n && fc == 1) begin
                sv_cnt = 0;
                gap_bad = 0;
                eos_len = 0;
            end
        end
        gap++;
        if (video_valid && !pvv) begin
            first_fc = fc;
            vv_rises++;
            gap = 0;
        end
        if (integrating && !pint) integ_fc = fc;
        if (!integrating && pint) integ_fl = fl;
        if (sample_valid && !psv && video_valid) sv_cnt++;
        if (pixel_index != pidx) begin
            if (video_valid && pvv && gap != 8 * HP) gap_bad++;
            gap = 0;
        end
        if (!scan_done_out_n) eos_len++;
        if (!scan_done_out_n && peos) eos_idx = pixel_index;
        ps = scan_clk;
        pvv = video_valid;
        pint = integrating;
        psv = sample_valid;
        peos = scan_done_out_n;
        pidx = pixel_index;
    end
    task end_of_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        n = 0;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) failures++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wait_on(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000) failures++;
    endtask : wait_on
    task run_line(input int ef, input int en);
        wait_on(line_n, 1'b0);
        wait_on(line_n, 1'b1);
        wait_on(video_valid, 1'b1);
        wait_on(video_valid, 1'b0);
        repeat (2) @(posedge clk);
        cmp(first_fc, ef);
        cmp(integ_fc, 2);
        cmp(sv_cnt, en);
        cmp(gap_bad, 0);
        cmp(eos_len, 8 * HP);
        cmp(eos_idx, en - 1);
        cmp(feedback_high_sens, gain);
    endtask : run_line
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, OFS_CONTROL, 32'h0, r);
        cmp(r[0], CONTROL_ENABLE_RESET);
        bus(1'b0, OFS_PIXELS, 32'h0, r);
        cmp(r[15:0], NF);
        bus(1'b0, OFS_LINES, 32'h0, l0);
        run_line(23, NF);
        bus(1'b0, OFS_LINES, 32'h0, r);
        cmp(r, l0 + 1);
        gain <= 1'b0;
        pitch <= 1'b0;
        run_line(23, NF / 2);
        bus(1'b0, OFS_PIXELS, 32'h0, r);
        cmp(r[15:0], NF / 2);
        role <= 1'b0;
        pitch <= 1'b1;
        run_line(33, NF);
        bus(1'b0, OFS_STATUS, 32'h0, r);
        cmp(r[10:1], 10'h002);
        role <= 1'b1;
        bus(1'b1, OFS_CONTROL, 32'h0, r);
        bus(1'b0, OFS_LINES, 32'h0, l0);
        v0 = vv_rises;
        repeat (2400) @(posedge clk);
        cmp(vv_rises, v0);
        bus(1'b0, OFS_LINES, 32'h0, r);
        cmp(r, l0);
        bus(1'b1, OFS_CONTROL, 32'h1, r);
        low_len <= 8'd14;
        wait_on(line_n, 1'b0);
        wait_on(line_n, 1'b1);
        wait_on(line_n, 1'b0);
        low_len <= 8'd12;
        wait_on(line_n, 1'b1);
        repeat (24) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0, r);
        cmp(r[ST_ERR_LOW], 1'b1);
        bus(1'b1, OFS_STATUS, 32'h200, r);
        bus(1'b0, OFS_STATUS, 32'h0, r);
        cmp(r[ST_ERR_LOW], 1'b0);
        cmp(integ_fl, 7);
        stall <= 1'b1;
        repeat (700) @(posedge clk);
        stall <= 1'b0;
        bus(1'b0, OFS_STATUS, 32'h0, r);
        cmp(r[ST_ERR_CLK], 1'b1);
        repeat (24) @(posedge clk);
        bus(1'b1, OFS_STATUS, 32'h400, r);
        bus(1'b0, OFS_STATUS, 32'h0, r);
        cmp(r[ST_ERR_CLK], 1'b0);
        end_of_test;
    end
    initial begin
        #(40 * 40000);
        failures++;
        end_of_test;
    end
endmodule : testbench
